/* rtl/codec_mixer_pkg.sv */
package codec_mixer_pkg;

   // -----------------------------------------------------------------
   // host port and index map
   // -----------------------------------------------------------------
   localparam logic       SEL_INDEX_ADDR  = 1'b0;
   localparam logic       SEL_INDEXED_DAT = 1'b1;
   localparam int         INDEX_W         = 5;
   localparam logic [4:0] IDX_LEFT_ADC    = 5'h00;
   localparam logic [4:0] IDX_RIGHT_ADC   = 5'h01;
   localparam logic [4:0] IDX_LEFT_AUX1   = 5'h02;
   localparam logic [4:0] IDX_RIGHT_AUX1  = 5'h03;
   localparam logic [4:0] IDX_LEFT_AUX2   = 5'h04;
   localparam logic [4:0] IDX_RIGHT_AUX2  = 5'h05;
   localparam logic [4:0] IDX_LEFT_DAC    = 5'h06;
   localparam logic [4:0] IDX_RIGHT_DAC   = 5'h07;
   localparam logic [4:0] IDX_RATE_FMT    = 5'h08;
   localparam logic [4:0] IDX_EXT_FIRST   = 5'h10;

   // -----------------------------------------------------------------
   // reset values and writable-bit masks (reserved bits kept zero)
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_ADC_CTL   = 8'h00;
   localparam logic [7:0] RST_AUX_CTL   = 8'h88;
   localparam logic [7:0] RST_DAC_CTL   = 8'h80;
   localparam logic [7:0] RST_RATE_FMT  = 8'h00;
   localparam logic [7:0] MASK_ADC_CTL  = 8'hef;
   localparam logic [7:0] MASK_AUX_CTL  = 8'h9f;
   localparam logic [7:0] MASK_DAC_CTL  = 8'hbf;
   localparam logic [7:0] MASK_CLK_RATE = 8'h0f;
   localparam logic [7:0] MASK_FMT_BITS = 8'hf0;

   // -----------------------------------------------------------------
   // source selects, divisors, format codes
   // -----------------------------------------------------------------
   localparam logic [1:0]  SRC_LINE     = 2'h0;
   localparam logic [1:0]  SRC_AUX_ONE  = 2'h1;
   localparam logic [1:0]  SRC_MIC      = 2'h2;
   localparam logic [1:0]  SRC_LOOPBACK = 2'h3;
   localparam logic [11:0] DIV_CODE0    = 12'hc00;
   localparam logic [11:0] DIV_CODE1    = 12'h600;
   localparam logic [11:0] DIV_CODE2    = 12'h380;
   localparam logic [11:0] DIV_CODE3    = 12'h300;
   localparam logic [11:0] DIV_CODE4    = 12'h1c0;
   localparam logic [11:0] DIV_CODE5    = 12'h180;
   localparam logic [11:0] DIV_CODE6    = 12'h200;
   localparam logic [11:0] DIV_CODE7    = 12'ha00;
   localparam logic [2:0]  FMT_U8       = 3'h0;
   localparam logic [2:0]  FMT_ULAW     = 3'h1;
   localparam logic [2:0]  FMT_S16_LE   = 3'h2;
   localparam logic [2:0]  FMT_ALAW     = 3'h3;
   localparam logic [2:0]  FMT_RSVD4    = 3'h4;
   localparam logic [2:0]  FMT_ADPCM    = 3'h5;
   localparam logic [2:0]  FMT_S16_BE   = 3'h6;
   localparam logic [2:0]  FMT_RSVD7    = 3'h7;

   // -----------------------------------------------------------------
   // register layouts
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] source_sel;
      logic       mic_boost_en;
      logic       rsvd;
      logic [3:0] gain;
   } adc_ctl_type;

   typedef struct packed {
      logic       mute;
      logic [1:0] rsvd;
      logic [4:0] gain;
   } aux_ctl_type;

   typedef struct packed {
      logic       mute;
      logic       rsvd;
      logic [5:0] atten;
   } dac_ctl_type;

   typedef struct packed {
      logic       format_high_bit;
      logic       format_low_bit;
      logic       companded_sel;
      logic       stereo;
      logic [2:0] rate_divide_sel;
      logic       sample_clock_source;
   } rate_fmt_type;

   // effective stream setup seen by the converters
   typedef struct packed {
      logic [2:0]  play_format;
      logic        play_stereo;
      logic [2:0]  capture_format;
      logic        capture_stereo;
      logic        sample_clock_source;
      logic [11:0] rate_divisor;
   } stream_cfg_type;

endpackage : codec_mixer_pkg

/* rtl/codec_indexed_mixer_format_regs.sv */
module codec_indexed_mixer_format_regs (
   input  wire logic                         i_clk,
   input  wire logic                         i_rstn,
   input  wire logic                         i_wr,
   input  wire logic                         i_rd,
   input  wire logic                         i_sel,
   input  wire logic [7:0]                   i_wdata,
   input  wire logic                         i_mode_change_enable,
   input  wire logic                         i_playback_mode_change_enable,
   input  wire logic                         i_extended_feature_select,
   input  wire logic [7:0]                   i_capture_format_reg,
   output logic      [7:0]                   o_rdata,
   output logic                              o_rvalid,
   output codec_mixer_pkg::adc_ctl_type      o_left_adc_ctl,
   output codec_mixer_pkg::adc_ctl_type      o_right_adc_ctl,
   output codec_mixer_pkg::aux_ctl_type      o_left_aux_one,
   output codec_mixer_pkg::aux_ctl_type      o_right_aux_one,
   output codec_mixer_pkg::aux_ctl_type      o_left_aux_two,
   output codec_mixer_pkg::aux_ctl_type      o_right_aux_two,
   output codec_mixer_pkg::dac_ctl_type      o_left_dac_ctl,
   output codec_mixer_pkg::dac_ctl_type      o_right_dac_ctl,
   output codec_mixer_pkg::rate_fmt_type     o_rate_format,
   output codec_mixer_pkg::stream_cfg_type   o_stream_cfg,
   output logic                              o_left_aux_one_muted,
   output logic                              o_right_aux_one_muted,
   output logic                              o_left_aux_two_muted,
   output logic                              o_right_aux_two_muted,
   output logic                              o_left_dac_muted,
   output logic                              o_right_dac_muted
);

   // -----------------------------------------------------------------
   // helper functions
   // -----------------------------------------------------------------

   // divide code to divisor; every code decodes, even fast ones
   function automatic logic [11:0] rate_divisor(input logic [2:0] code);
      logic [11:0] div;
      div = codec_mixer_pkg::DIV_CODE0;
      case (code)
         3'h0: div = codec_mixer_pkg::DIV_CODE0;
         3'h1: div = codec_mixer_pkg::DIV_CODE1;
         3'h2: div = codec_mixer_pkg::DIV_CODE2;
         3'h3: div = codec_mixer_pkg::DIV_CODE3;
         3'h4: div = codec_mixer_pkg::DIV_CODE4;
         3'h5: div = codec_mixer_pkg::DIV_CODE5;
         3'h6: div = codec_mixer_pkg::DIV_CODE6;
         default: div = codec_mixer_pkg::DIV_CODE7;
      endcase
      return div;
   endfunction : rate_divisor

   // format triple, high bit held low outside extended mode
   function automatic logic [2:0] eff_format(input logic       ext,
                                             input logic [2:0] raw);
      return {raw[2] & ext, raw[1:0]};
   endfunction : eff_format

   // masked merge of a host write into a stored byte
   function automatic logic [7:0] merge(input logic [7:0] old_val,
                                        input logic [7:0] new_val,
                                        input logic [7:0] mask);
      return (old_val & ~mask) | (new_val & mask);
   endfunction : merge

   // -----------------------------------------------------------------
   // storage
   // -----------------------------------------------------------------
   logic [4:0]                   index_reg;
   logic [4:0]                   index_next;
   codec_mixer_pkg::adc_ctl_type left_adc_reg;
   codec_mixer_pkg::adc_ctl_type right_adc_reg;
   codec_mixer_pkg::aux_ctl_type left_aux1_reg;
   codec_mixer_pkg::aux_ctl_type right_aux1_reg;
   codec_mixer_pkg::aux_ctl_type left_aux2_reg;
   codec_mixer_pkg::aux_ctl_type right_aux2_reg;
   codec_mixer_pkg::dac_ctl_type left_dac_reg;
   codec_mixer_pkg::dac_ctl_type right_dac_reg;
   codec_mixer_pkg::rate_fmt_type rate_fmt_reg;
   codec_mixer_pkg::rate_fmt_type rate_fmt_next;
   logic [7:0]                   rdata_next;

   // -----------------------------------------------------------------
   // access decode
   // -----------------------------------------------------------------

   // the extended window is closed unless the mode bit is set
   wire ext_window  = (index_reg >= codec_mixer_pkg::IDX_EXT_FIRST);
   wire index_open  = ~ext_window | i_extended_feature_select;
   wire wr_index    = i_wr & (i_sel == codec_mixer_pkg::SEL_INDEX_ADDR);
   wire wr_data     = i_wr & (i_sel == codec_mixer_pkg::SEL_INDEXED_DAT)
                      & index_open;
   wire rd_data     = i_rd & (i_sel == codec_mixer_pkg::SEL_INDEXED_DAT);

   // per-register write strobes from the latched index
   wire wr_left_adc   = wr_data & (index_reg == codec_mixer_pkg::IDX_LEFT_ADC);
   wire wr_right_adc  = wr_data
                        & (index_reg == codec_mixer_pkg::IDX_RIGHT_ADC);
   wire wr_left_aux1  = wr_data
                        & (index_reg == codec_mixer_pkg::IDX_LEFT_AUX1);
   wire wr_right_aux1 = wr_data
                        & (index_reg == codec_mixer_pkg::IDX_RIGHT_AUX1);
   wire wr_left_aux2  = wr_data
                        & (index_reg == codec_mixer_pkg::IDX_LEFT_AUX2);
   wire wr_right_aux2 = wr_data
                        & (index_reg == codec_mixer_pkg::IDX_RIGHT_AUX2);
   wire wr_left_dac   = wr_data & (index_reg == codec_mixer_pkg::IDX_LEFT_DAC);
   wire wr_right_dac  = wr_data
                        & (index_reg == codec_mixer_pkg::IDX_RIGHT_DAC);
   wire wr_rate_fmt   = wr_data & (index_reg == codec_mixer_pkg::IDX_RATE_FMT);

   // index register takes the low five bits of a write
   assign index_next = wr_index ? i_wdata[4:0] : index_reg;

   // -----------------------------------------------------------------
   // rate and format write gating
   // -----------------------------------------------------------------

   // clock and divide need the full mode-change enable; format bits
   // also accept the playback enable, so playback format can move
   // while capture keeps running
   wire fmt_open   = i_mode_change_enable | i_playback_mode_change_enable;
   wire [7:0] rate_mask =
      (i_mode_change_enable ? codec_mixer_pkg::MASK_CLK_RATE : 8'h00) |
      (fmt_open ? codec_mixer_pkg::MASK_FMT_BITS : 8'h00);

   // masked bits keep their stored value
   assign rate_fmt_next = wr_rate_fmt ?
      merge(rate_fmt_reg, i_wdata, rate_mask) : rate_fmt_reg;

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------

   // stored format high bit reads back as zero in basic mode
   wire [7:0] rate_fmt_view = {
      eff_format(i_extended_feature_select,
                 {rate_fmt_reg.format_high_bit,
                  rate_fmt_reg.format_low_bit,
                  rate_fmt_reg.companded_sel}),
      rate_fmt_reg[4:0]};

   // indexed read; unmapped or closed indexes return zero
   wire [7:0] indexed_view =
      ~index_open ? 8'h00 :
      (index_reg == codec_mixer_pkg::IDX_LEFT_ADC)   ? left_adc_reg   :
      (index_reg == codec_mixer_pkg::IDX_RIGHT_ADC)  ? right_adc_reg  :
      (index_reg == codec_mixer_pkg::IDX_LEFT_AUX1)  ? left_aux1_reg  :
      (index_reg == codec_mixer_pkg::IDX_RIGHT_AUX1) ? right_aux1_reg :
      (index_reg == codec_mixer_pkg::IDX_LEFT_AUX2)  ? left_aux2_reg  :
      (index_reg == codec_mixer_pkg::IDX_RIGHT_AUX2) ? right_aux2_reg :
      (index_reg == codec_mixer_pkg::IDX_LEFT_DAC)   ? left_dac_reg   :
      (index_reg == codec_mixer_pkg::IDX_RIGHT_DAC)  ? right_dac_reg  :
      (index_reg == codec_mixer_pkg::IDX_RATE_FMT)   ? rate_fmt_view  :
      8'h00;

   assign rdata_next = rd_data ? indexed_view : {3'h0, index_reg};

   // -----------------------------------------------------------------
   // effective stream setup
   // -----------------------------------------------------------------

   // capture follows this register in basic mode, its own in extended
   wire [2:0] play_fmt_w = rate_fmt_view[7:5];
   wire [2:0] cap_fmt_w  = i_extended_feature_select ?
                           i_capture_format_reg[7:5] : play_fmt_w;
   wire       cap_st_w   = i_extended_feature_select ?
                           i_capture_format_reg[4]
                           : rate_fmt_reg.stereo;
   codec_mixer_pkg::stream_cfg_type cfg_next;
   assign cfg_next = '{
      play_format:         play_fmt_w,
      play_stereo:         rate_fmt_reg.stereo,
      capture_format:      cap_fmt_w,
      capture_stereo:      cap_st_w,
      sample_clock_source: rate_fmt_reg.sample_clock_source,
      rate_divisor:        rate_divisor(rate_fmt_reg.rate_divide_sel)
   };

   // -----------------------------------------------------------------
   // host port registers
   // -----------------------------------------------------------------

   // index and read data; a read of the data port answers next cycle
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         index_reg <= 5'h00;
         o_rdata   <= 8'h00;
         o_rvalid  <= 1'b0;
      end else begin
         index_reg <= index_next;
         o_rdata   <= i_rd ? rdata_next : o_rdata;
         o_rvalid  <= i_rd;
      end
   end

   // -----------------------------------------------------------------
   // mixer registers
   // -----------------------------------------------------------------

   // input and output controls; reserved bits are stored as zero
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         left_adc_reg   <= codec_mixer_pkg::RST_ADC_CTL;
         right_adc_reg  <= codec_mixer_pkg::RST_ADC_CTL;
         left_aux1_reg  <= codec_mixer_pkg::RST_AUX_CTL;
         right_aux1_reg <= codec_mixer_pkg::RST_AUX_CTL;
         left_aux2_reg  <= codec_mixer_pkg::RST_AUX_CTL;
         right_aux2_reg <= codec_mixer_pkg::RST_AUX_CTL;
         left_dac_reg   <= codec_mixer_pkg::RST_DAC_CTL;
         right_dac_reg  <= codec_mixer_pkg::RST_DAC_CTL;
      end else begin
         if (wr_left_adc)
            left_adc_reg <= i_wdata & codec_mixer_pkg::MASK_ADC_CTL;
         if (wr_right_adc)
            right_adc_reg <= i_wdata & codec_mixer_pkg::MASK_ADC_CTL;
         if (wr_left_aux1)
            left_aux1_reg <= i_wdata & codec_mixer_pkg::MASK_AUX_CTL;
         if (wr_right_aux1)
            right_aux1_reg <= i_wdata & codec_mixer_pkg::MASK_AUX_CTL;
         if (wr_left_aux2)
            left_aux2_reg <= i_wdata & codec_mixer_pkg::MASK_AUX_CTL;
         if (wr_right_aux2)
            right_aux2_reg <= i_wdata & codec_mixer_pkg::MASK_AUX_CTL;
         if (wr_left_dac)
            left_dac_reg <= i_wdata & codec_mixer_pkg::MASK_DAC_CTL;
         if (wr_right_dac)
            right_dac_reg <= i_wdata & codec_mixer_pkg::MASK_DAC_CTL;
      end
   end

   // rate and format, gated per field
   always_ff @(posedge i_clk) begin
      if (!i_rstn)
         rate_fmt_reg <= codec_mixer_pkg::RST_RATE_FMT;
      else
         rate_fmt_reg <= rate_fmt_next;
   end

   // -----------------------------------------------------------------
   // registered outputs
   // -----------------------------------------------------------------

   // mirror copies so every output leaves a flip-flop; one cycle late
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_left_adc_ctl  <= codec_mixer_pkg::RST_ADC_CTL;
         o_right_adc_ctl <= codec_mixer_pkg::RST_ADC_CTL;
         o_left_aux_one  <= codec_mixer_pkg::RST_AUX_CTL;
         o_right_aux_one <= codec_mixer_pkg::RST_AUX_CTL;
         o_left_aux_two  <= codec_mixer_pkg::RST_AUX_CTL;
         o_right_aux_two <= codec_mixer_pkg::RST_AUX_CTL;
         o_left_dac_ctl  <= codec_mixer_pkg::RST_DAC_CTL;
         o_right_dac_ctl <= codec_mixer_pkg::RST_DAC_CTL;
         o_rate_format   <= codec_mixer_pkg::RST_RATE_FMT;
      end else begin
         o_left_adc_ctl  <= left_adc_reg;
         o_right_adc_ctl <= right_adc_reg;
         o_left_aux_one  <= left_aux1_reg;
         o_right_aux_one <= right_aux1_reg;
         o_left_aux_two  <= left_aux2_reg;
         o_right_aux_two <= right_aux2_reg;
         o_left_dac_ctl  <= left_dac_reg;
         o_right_dac_ctl <= right_dac_reg;
         o_rate_format   <= rate_fmt_view;
      end
   end

   // mute levels toward the analog mixer
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_left_aux_one_muted  <= 1'b1;
         o_right_aux_one_muted <= 1'b1;
         o_left_aux_two_muted  <= 1'b1;
         o_right_aux_two_muted <= 1'b1;
         o_left_dac_muted      <= 1'b1;
         o_right_dac_muted     <= 1'b1;
      end else begin
         o_left_aux_one_muted  <= left_aux1_reg.mute;
         o_right_aux_one_muted <= right_aux1_reg.mute;
         o_left_aux_two_muted  <= left_aux2_reg.mute;
         o_right_aux_two_muted <= right_aux2_reg.mute;
         o_left_dac_muted      <= left_dac_reg.mute;
         o_right_dac_muted     <= right_dac_reg.mute;
      end
   end

   // stream setup, reset state is code 0 mono on the first clock
   always_ff @(posedge i_clk) begin
      if (!i_rstn)
         o_stream_cfg <= '{play_format: codec_mixer_pkg::FMT_U8,
                           play_stereo: 1'b0,
                           capture_format: codec_mixer_pkg::FMT_U8,
                           capture_stereo: 1'b0,
                           sample_clock_source: 1'b0,
                           rate_divisor: codec_mixer_pkg::DIV_CODE0};
      else
         o_stream_cfg <= cfg_next;
   end

endmodule : codec_indexed_mixer_format_regs

/* sim/codec_regs_checker.sv */
module codec_regs_checker (
   input wire logic                            i_clk,
   input wire logic                            i_rstn,
   input wire logic                            i_wr,
   input wire logic                            i_rd,
   input wire logic                            i_sel,
   input wire logic                            i_mode_change_enable,
   input wire logic                            i_playback_mode_change_enable,
   input wire logic                            i_extended_feature_select,
   input wire logic                            o_rvalid,
   input wire codec_mixer_pkg::aux_ctl_type    o_left_aux_one,
   input wire logic                            o_left_aux_one_muted,
   input wire codec_mixer_pkg::rate_fmt_type   o_rate_format,
   input wire codec_mixer_pkg::stream_cfg_type o_stream_cfg
);
   timeunit 1ns;
   timeprecision 1ns;
   // -------------------------------------------------------------
   // helpers and properties
   // -------------------------------------------------------------
   localparam logic [11:0] DIVS [8] = '{12'hc00, 12'h600, 12'h380,
      12'h300, 12'h1c0, 12'h180, 12'h200, 12'ha00};
   logic clk_wr_q;
   logic fmt_wr_q;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // data-port writes that may touch gated fields, one cycle late
   always_ff @(posedge i_clk) begin
      clk_wr_q <= i_wr & i_sel & i_mode_change_enable;
      fmt_wr_q <= i_wr & i_sel & (i_mode_change_enable
                  | i_playback_mode_change_enable);
   end
   AST_READ_ANSWER: assert property (i_rd |=> o_rvalid)
      else $error("read not answered");
   AST_NO_SPURIOUS: assert property (!i_rd |=> !o_rvalid)
      else $error("answer without read");
   AST_AUX_MUTE: assert property (
      o_left_aux_one_muted == o_left_aux_one.mute)
      else $error("aux mute level wrong");
   AST_CLOCK_GATED: assert property (
      $changed(o_rate_format[3:0]) |-> $past(clk_wr_q))
      else $error("clock fields changed ungated");
   AST_FMT_GATED: assert property (
      $changed(o_rate_format[6:4]) |-> $past(fmt_wr_q))
      else $error("format fields changed ungated");
   AST_BASIC_HIGH_ZERO: assert property (
      !$past(i_extended_feature_select) |-> !o_rate_format.format_high_bit)
      else $error("format high bit not forced");
   AST_DIVISOR_MAP: assert property (
      o_stream_cfg.rate_divisor == DIVS[o_rate_format.rate_divide_sel])
      else $error("divisor mismatch");
   AST_PLAY_FORMAT: assert property (
      {o_stream_cfg.play_format, o_stream_cfg.play_stereo}
      == o_rate_format[7:4])
      else $error("playback format mismatch");
   AST_BASIC_CAPTURE: assert property (
      !$past(i_extended_feature_select) |-> o_stream_cfg.capture_format
      == o_stream_cfg.play_format)
      else $error("capture format not shared");
   // main scenarios reached
   cover property (i_wr && i_sel && i_playback_mode_change_enable);
   cover property (i_extended_feature_select && o_rvalid);
   cover property ($changed(o_rate_format[3:0]));
endmodule : codec_regs_checker

bind codec_indexed_mixer_format_regs codec_regs_checker codec_regs_checker_inst (
   .i_clk, .i_rstn, .i_wr, .i_rd, .i_sel, .i_mode_change_enable,
   .i_playback_mode_change_enable, .i_extended_feature_select, .o_rvalid,
   .o_left_aux_one, .o_left_aux_one_muted, .o_rate_format, .o_stream_cfg);

/* sim/codec_host_model.sv */
module codec_host_model (
   input  wire logic       i_clk,
   input  wire logic       i_rvalid,
   input  wire logic [7:0] i_rdata,
   output logic            o_wr,
   output logic            o_rd,
   output logic            o_sel,
   output logic      [7:0] o_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // -------------------------------------------------------------
   // host bus cycles
   // -------------------------------------------------------------
   // idle bus from time zero
   initial begin
      o_wr = 1'b0; o_rd = 1'b0; o_sel = 1'b0; o_wdata = 8'h00;
   end
   // index first, data access next
   task automatic put_index(input logic [4:0] idx);
      @(posedge i_clk); #1;
      o_wr = 1'b1; o_sel = 1'b0; o_wdata = {3'h0, idx};
   endtask : put_index
   task automatic write_reg(input logic [4:0] idx, input logic [7:0] v);
      put_index(idx);
      @(posedge i_clk); #1;
      o_sel = 1'b1; o_wdata = v;
      @(posedge i_clk); #1;
      o_wr = 1'b0; o_wdata = ~v; // released data never repeats the value
   endtask : write_reg
   task automatic read_reg(input logic [4:0] idx, output logic [7:0] v);
      put_index(idx);
      @(posedge i_clk); #1;
      o_wr = 1'b0; o_rd = 1'b1; o_sel = 1'b1; o_wdata = ~o_wdata;
      @(posedge i_clk); #1;
      o_rd = 1'b0;
      v = i_rvalid ? i_rdata : 8'hxx; // no answer makes a mismatch
   endtask : read_reg
endmodule : codec_host_model

/* sim/codec_indexed_mixer_format_regs_test.sv */
module codec_indexed_mixer_format_regs_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] RST [9] = '{8'h00, 8'h00, 8'h88, 8'h88, 8'h88,
      8'h88, 8'h80, 8'h80, 8'h00};
   localparam logic [7:0] PAT [8] = '{8'h6a, 8'hc5, 8'h13, 8'h0c, 8'h1f,
      8'h81, 8'h3f, 8'h2a};
   localparam logic [11:0] DIVS [8] = '{12'hc00, 12'h600, 12'h380,
      12'h300, 12'h1c0, 12'h180, 12'h200, 12'ha00};
   // pattern index seen on each otherwise unwatched mirror
   localparam int MI [5] = '{1, 3, 4, 5, 7};
   logic clk = 1'b0, rstn = 1'b0, chg_en = 1'b0, play_chg_en = 1'b0;
   logic ext = 1'b0;
   logic wr, rd, sel, rvalid, aux_muted, dac_muted;
   logic [7:0] wdata, rdata, cap_fmt = 8'h00, v;
   codec_mixer_pkg::adc_ctl_type    adc_l;
   codec_mixer_pkg::aux_ctl_type    aux_l;
   codec_mixer_pkg::dac_ctl_type    dac_l;
   codec_mixer_pkg::stream_cfg_type cfg;
   logic [7:0] mir [5];
   logic [3:0] mutes;
   int mismatches = 0, checks_done = 0;
   always #25 clk = ~clk;
   codec_host_model codec_host_model_inst (.i_clk(clk), .i_rvalid(rvalid),
      .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_sel(sel), .o_wdata(wdata));
   codec_indexed_mixer_format_regs codec_indexed_mixer_format_regs_inst (
      .i_clk(clk), .i_rstn(rstn), .i_wr(wr), .i_rd(rd), .i_sel(sel),
      .i_wdata(wdata), .i_mode_change_enable(chg_en),
      .i_playback_mode_change_enable(play_chg_en),
      .i_extended_feature_select(ext), .i_capture_format_reg(cap_fmt),
      .o_rdata(rdata), .o_rvalid(rvalid), .o_left_adc_ctl(adc_l),
      .o_right_adc_ctl(mir[0]), .o_left_aux_one(aux_l),
      .o_right_aux_one(mir[1]), .o_left_aux_two(mir[2]),
      .o_right_aux_two(mir[3]), .o_left_dac_ctl(dac_l),
      .o_right_dac_ctl(mir[4]), .o_rate_format(), .o_stream_cfg(cfg),
      .o_left_aux_one_muted(aux_muted), .o_right_aux_one_muted(mutes[3]),
      .o_left_aux_two_muted(mutes[2]), .o_right_aux_two_muted(mutes[1]),
      .o_left_dac_muted(dac_muted), .o_right_dac_muted(mutes[0]));
   // -------------------------------------------------------------
   // checking and scenarios
   // -------------------------------------------------------------
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test();
      $display("mismatches %0d checks %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test
   task automatic rw(input logic [4:0] i, input logic [7:0] w,
                     input logic [7:0] e);
      codec_host_model_inst.write_reg(i, w);
      codec_host_model_inst.read_reg(i, v);
      chk({4'h0, v}, {4'h0, e});
   endtask : rw
   task automatic t_reset();
      for (int i = 0; i < 9; i++) begin
         codec_host_model_inst.read_reg(i[4:0], v);
         chk({4'h0, v}, {4'h0, RST[i]});
      end
      chk({11'h0, aux_muted & dac_muted & (&mutes)}, 12'h1);
   endtask : t_reset
   task automatic t_fields();
      for (int i = 0; i < 8; i++) rw(i[4:0], PAT[i], PAT[i]);
      chk({4'h0, aux_l}, 12'h013);
      chk({11'h0, aux_muted}, 12'h0);
      chk({11'h0, dac_muted}, 12'h0);
      for (int k = 0; k < 5; k++)
         chk({4'h0, mir[k]}, {4'h0, PAT[MI[k]]});
      chk({8'h0, mutes}, 12'h002);
      for (int s = 0; s < 4; s++) begin
         rw(5'h00, {s[1:0], 6'h00}, {s[1:0], 6'h00});
         chk({10'h0, adc_l.source_sel}, s[11:0]);
      end
   endtask : t_fields
   task automatic t_gate();
      ext = 1'b1;
      rw(5'h08, 8'hff, 8'h00);
      play_chg_en = 1'b1;
      rw(5'h08, 8'hff, 8'hf0);
      play_chg_en = 1'b0;
      chg_en = 1'b1;
      for (int k = 0; k < 8; k++) begin
         rw(5'h08, {4'h0, k[2:0], 1'b1}, {4'h0, k[2:0], 1'b1});
         chk(cfg.rate_divisor, DIVS[k]);
         chk({11'h0, cfg.sample_clock_source}, 12'h1);
      end
      for (int f = 0; f < 8; f++) begin
         rw(5'h08, {f[2:0], 5'h10}, {f[2:0], 5'h10});
         chk({9'h0, cfg.play_format}, f[11:0]);
         chk({11'h0, cfg.play_stereo}, 12'h1);
      end
      ext = 1'b0;
      rw(5'h08, 8'he0, 8'h60);
      chg_en = 1'b0;
   endtask : t_gate
   task automatic t_ext();
      rw(5'h10, 8'h5a, 8'h00);
      ext = 1'b1;
      cap_fmt = 8'hb0;
      repeat (2) @(posedge clk);
      #1;
      chk({8'h0, cfg.capture_format, cfg.capture_stereo}, 12'hb);
      ext = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({9'h0, cfg.capture_format}, 12'h3);
   endtask : t_ext
   // main sequence, reset held ten cycles
   initial begin
      repeat (10) @(posedge clk);
      #1;
      rstn = 1'b1;
      t_reset();
      t_fields();
      t_gate();
      t_ext();
      finish_test();
   end
   // hang guard, far beyond the few hundred cycles above
   initial begin
      #(20000 * 50);
      mismatches++;
      finish_test();
   end
endmodule : codec_indexed_mixer_format_regs_test
